// ### common/scsp_pkg.sv
// Constants and types for the system clock source and prescaler block.
// Assumes a single clk_sys domain and an APB register slave.
package scsp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 2;
  localparam int DIV_W = 10;
  localparam int WAIT_W = 4;
  localparam int NPIN = 4;
  // Pin indices in the synchroniser vector
  localparam int PIN_EXT = 0;
  localparam int PIN_OSC = 1;
  localparam int PIN_PLL = 2;
  localparam int PIN_WU = 3;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_SYSCTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PLLCTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MEMCTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  // Field positions
  localparam int VCO_BYPASS_BIT = 0;
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_VCO_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_DIV_LSB = 16;
  // Source select codes
  localparam logic [SEL_W-1:0] SEL_WAKEUP = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RESERVED = 2'h1;
  localparam logic [SEL_W-1:0] SEL_PRESCALE = 2'h2;
  localparam logic [SEL_W-1:0] SEL_DIRECT = 2'h3;
  // Reset values
  localparam logic [SEL_W-1:0] RST_SEL = SEL_WAKEUP;
  localparam logic RST_VCO_BYPASS = 1'b1;
  localparam logic [DIV_W-1:0] RST_DIV = 10'h000;
  localparam logic [WAIT_W-1:0] RST_WAIT = 4'h4;
  typedef enum logic [1:0] {ST_RUN, ST_PARK, ST_SWITCH, ST_WAIT_LOW} scsp_state_type;
endpackage

// ### common/scsp_div_if.sv
// Link between the clock selector and its oscillator prescaler.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface scsp_div_if;
  import scsp_pkg::*;
  logic oscLevel;
  logic load;
  logic [DIV_W-1:0] divField;
  logic [DIV_W-1:0] activeDiv;
  logic divClk;
  modport ctrl(output oscLevel, output load, output divField, input activeDiv, input divClk);
  modport div(input oscLevel, input load, input divField, output activeDiv, output divClk);
endinterface

// ### hw/scsp_divider.sv
// Oscillator prescaler: divides the synchronised oscillator level by field plus one.
// Assumes oscLevel is already synchronised to clk_sys.
`timescale 1ns/1ps
module scsp_divider
  import scsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  scsp_div_if.div dif
);
  typedef struct packed {
    logic prev;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] field;
    logic out;
  } scsp_div_state_type;

  scsp_div_state_type s_r;
  scsp_div_state_type s_nxt;
  logic oscRise;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = dif.oscLevel;
    oscRise = dif.oscLevel & ~s_r.prev;
    if (dif.load) begin
      s_nxt.field = dif.divField;
      s_nxt.cnt = dif.divField;
      s_nxt.out = 1'b0;
    end else if (s_r.field == '0) begin
      s_nxt.out = dif.oscLevel;
    end else if (oscRise) begin
      if (s_r.cnt == s_r.field) begin
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = DIV_W'(s_r.cnt + 1'b1);
      end
      s_nxt.out = (s_nxt.cnt <= (s_r.field >> 1));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.field <= RST_DIV;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dif.divClk = s_r.out;
  assign dif.activeDiv = s_r.field;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_div_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_r.field == '0 && !dif.load) |=> dif.divClk == $past(dif.oscLevel))
    else $error("Factor one does not pass the oscillator through");
  a_div_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    (oscRise && s_r.cnt == s_r.field && !dif.load) |=> (s_r.cnt == '0 && dif.divClk))
    else $error("Prescaler period is not field plus one");
endmodule // scsp_divider

// ### hw/scsp_top.sv
// System clock source selector and prescaler with flash wait-state timing.
// Assumes APB on clk_sys; clock pins are asynchronous and sampled by two flops.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module scsp_top
  import scsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockInputPin,
  input wire logic oscClkIn,
  input wire logic pllClkIn,
  input wire logic wakeupClkIn,
  output logic sysClkOut,
  output logic pllEnable,
  input wire logic flashReq,
  input wire logic flashSeq,
  output logic flashReady
);
  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [SEL_W-1:0] selReg;
    logic vco_bypass;
    logic [DIV_W-1:0] divField;
    logic [WAIT_W-1:0] waitCnt;
    logic [SEL_W-1:0] actSel;
    logic actVco;
    scsp_state_type state;
    logic sysClk;
    logic sysPrev;
    logic pllEn;
    logic flashBusy;
    logic [WAIT_W-1:0] flashCnt;
    logic flashAck;
    logic [DATA_W-1:0] rdata;
    logic slvErr;
  } scsp_top_state_type;

  scsp_top_state_type s_r;
  scsp_top_state_type s_nxt;
  scsp_div_if dif();
  logic [NPIN-1:0] pinVec;
  logic src;
  logic cfgDiff;
  logic sysRise;
  logic flashStart;
  logic apbSetup;
  logic apbWrite;
  logic [DATA_W-1:0] statusWord;

  assign pinVec = {wakeupClkIn, pllClkIn, oscClkIn, extClockInputPin};

  scsp_divider u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .dif(dif.div)
  );

  assign dif.oscLevel = s_r.sync2[PIN_OSC];
  assign dif.divField = s_r.divField;
  assign dif.load = (s_r.state == ST_PARK) && !s_r.sysClk;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pinVec;
    s_nxt.sync2 = s_r.sync1;
    apbSetup = psel & ~penable;
    apbWrite = psel & penable & pwrite;
    cfgDiff = (s_r.selReg != s_r.actSel) || (s_r.vco_bypass != s_r.actVco) ||
              (s_r.divField != dif.activeDiv);
    sysRise = s_r.sysClk & ~s_r.sysPrev;
    flashStart = ~s_r.flashBusy & flashReq & ~s_r.flashAck;
    statusWord = '0;
    statusWord[STAT_SEL_LSB +: SEL_W] = s_r.actSel;
    statusWord[STAT_VCO_BIT] = s_r.actVco;
    statusWord[STAT_BUSY_BIT] = (s_r.state != ST_RUN) || cfgDiff;
    statusWord[STAT_DIV_LSB +: DIV_W] = dif.activeDiv;

    // Register writes
    if (apbWrite) begin
      unique case (paddr)
        OFF_SYSCTRL: s_nxt.selReg = pwdata[SEL_W-1:0];
        OFF_PLLCTRL: s_nxt.vco_bypass = pwdata[VCO_BYPASS_BIT];
        OFF_PRESCALE: s_nxt.divField = pwdata[DIV_W-1:0];
        OFF_MEMCTRL: s_nxt.waitCnt = pwdata[WAIT_W-1:0];
        default: s_nxt.rdata = s_r.rdata;
      endcase
    end
    // Read data and error are captured in the setup cycle
    if (apbSetup) begin
      s_nxt.slvErr = 1'b0;
      s_nxt.rdata = '0;
      unique case (paddr)
        OFF_SYSCTRL: s_nxt.rdata[SEL_W-1:0] = s_r.selReg;
        OFF_PLLCTRL: s_nxt.rdata[VCO_BYPASS_BIT] = s_r.vco_bypass;
        OFF_PRESCALE: s_nxt.rdata[DIV_W-1:0] = s_r.divField;
        OFF_MEMCTRL: s_nxt.rdata[WAIT_W-1:0] = s_r.waitCnt;
        OFF_STATUS: s_nxt.rdata = statusWord;
        default: s_nxt.slvErr = 1'b1;
      endcase
    end

    s_nxt.pllEn = (s_r.selReg == SEL_PRESCALE) && !s_r.vco_bypass;

    // Source selection
    unique case (s_r.actSel)
      SEL_DIRECT: src = s_r.sync2[PIN_EXT];
      SEL_PRESCALE: src = s_r.actVco ? dif.divClk : s_r.sync2[PIN_PLL];
      SEL_WAKEUP: src = s_r.sync2[PIN_WU];
      SEL_RESERVED: src = 1'b0;
    endcase

    // Glitch-free switch sequence
    s_nxt.sysPrev = s_r.sysClk;
    unique case (s_r.state)
      ST_RUN: begin
        s_nxt.sysClk = src;
        if (cfgDiff) begin
          s_nxt.state = ST_PARK;
        end
      end
      ST_PARK: begin
        s_nxt.sysClk = s_r.sysClk & src;
        if (!s_r.sysClk) begin
          s_nxt.sysClk = 1'b0;
          s_nxt.actSel = s_r.selReg;
          s_nxt.actVco = s_r.vco_bypass;
          s_nxt.state = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        s_nxt.sysClk = 1'b0;
        s_nxt.state = ST_WAIT_LOW;
      end
      ST_WAIT_LOW: begin
        s_nxt.sysClk = 1'b0;
        if (!src) begin
          s_nxt.state = ST_RUN;
        end
      end
    endcase

    // Flash access timing on system clock edges
    s_nxt.flashAck = 1'b0;
    if (flashStart) begin
      s_nxt.flashBusy = 1'b1;
      s_nxt.flashCnt = flashSeq ? '0 : s_r.waitCnt;
    end else if (s_r.flashBusy && sysRise) begin
      if (s_r.flashCnt == '0) begin
        s_nxt.flashBusy = 1'b0;
        s_nxt.flashAck = 1'b1;
      end else begin
        s_nxt.flashCnt = WAIT_W'(s_r.flashCnt - 1'b1);
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.selReg <= RST_SEL;
      s_r.actSel <= RST_SEL;
      s_r.vco_bypass <= RST_VCO_BYPASS;
      s_r.actVco <= RST_VCO_BYPASS;
      s_r.divField <= RST_DIV;
      s_r.waitCnt <= RST_WAIT;
      s_r.state <= ST_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = s_r.slvErr;
  assign sysClkOut = s_r.sysClk;
  assign pllEnable = s_r.pllEn;
  assign flashReady = s_r.flashAck;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence parkedLow;
    s_r.state == ST_PARK && !s_r.sysClk;
  endsequence
  sequence switchHold;
    s_r.state == ST_SWITCH && !s_r.sysClk ##1 s_r.state == ST_WAIT_LOW && !s_r.sysClk;
  endsequence

  a_direct_drive: assert property (
    (s_r.state == ST_RUN && !cfgDiff && s_r.actSel == SEL_DIRECT) |=>
      s_r.sysClk == $past(s_r.sync2[PIN_EXT]))
    else $error("Direct drive does not follow the external pin");
  a_prescale_path: assert property (
    (s_r.state == ST_RUN && !cfgDiff && s_r.actSel == SEL_PRESCALE && s_r.actVco) |=>
      s_r.sysClk == $past(dif.divClk))
    else $error("Prescaler mode does not follow the divider");
  a_pll_enable: assert property (
    (s_r.selReg == SEL_PRESCALE && !s_r.vco_bypass) |=> pllEnable)
    else $error("PLL not enabled in PLL mode");
  a_wakeup_path: assert property (
    (s_r.state == ST_RUN && !cfgDiff && s_r.actSel == SEL_WAKEUP) |=>
      s_r.sysClk == $past(s_r.sync2[PIN_WU]))
    else $error("Wakeup mode does not follow the wakeup clock");
  a_switch_steps: assert property (
    parkedLow |=> switchHold)
    else $error("Switch sequence skipped a low step");
  a_no_runt_rise: assert property (
    $rose(s_r.sysClk) |-> $past(s_r.state) == ST_RUN)
    else $error("System clock rose outside normal running");
  a_flash_nonseq: assert property (
    (flashStart && !flashSeq) |=> (s_r.flashBusy && s_r.flashCnt == $past(s_r.waitCnt)))
    else $error("Non-sequential access lost its wait states");
  a_flash_seq: assert property (
    (flashStart && flashSeq) |=> (s_r.flashBusy && s_r.flashCnt == '0))
    else $error("Sequential access was charged wait states");
  a_ready_on_edge: assert property (
    flashReady |-> $past(sysRise) && !s_r.flashBusy)
    else $error("Flash ready not tied to a system clock edge");
endmodule // scsp_top

// ### sim/scsp_clk_model.sv
// Free-running clock sources: external pin, oscillator, PLL output, wakeup.
// Assumes a 50 ns clk_sys; phases are offset so no edge meets a clk_sys edge.
`timescale 1ns/1ps
module scsp_clk_model #(
  parameter int HALF_EXT = 150,
  parameter int HALF_OSC = 200,
  parameter int HALF_PLL = 100,
  parameter int HALF_WU = 300
) (
  output logic extClk,
  output logic oscClk,
  output logic pllClk,
  output logic wuClk
);
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  initial begin
    extClk = 1'b0;
    #13;
    forever #HALF_EXT extClk = ~extClk;
  end
  initial begin
    oscClk = 1'b0;
    #13;
    forever #HALF_OSC oscClk = ~oscClk;
  end
  initial begin
    pllClk = 1'b0;
    #13;
    forever #HALF_PLL pllClk = ~pllClk;
  end
  initial begin
    wuClk = 1'b0;
    #13;
    forever #HALF_WU wuClk = ~wuClk;
  end
endmodule // scsp_clk_model

// ### sim/tb.sv
// Self-checking bench for scsp_top: APB setup, clock periods, flash timing.
// Assumes the source model half periods of 3, 4, 2 and 6 clk_sys cycles.
`timescale 1ns/1ps
module tb;
  import scsp_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, prevSys, arm;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic extPin, oscClk, pllClk, wuClk, sysClkOut, pllEnable;
  logic flashReq, flashSeq, flashReady;
  int err_count = 0;
  int samples_checked = 0;
  int runLen = 0;
  int minPulse = 99;
  scsp_clk_model src (.extClk(extPin), .oscClk(oscClk), .pllClk(pllClk), .wuClk(wuClk));
  scsp_top dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extClockInputPin(extPin), .oscClkIn(oscClk), .pllClkIn(pllClk),
    .wakeupClkIn(wuClk), .sysClkOut(sysClkOut), .pllEnable(pllEnable),
    .flashReq(flashReq), .flashSeq(flashSeq), .flashReady(flashReady));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (sysClkOut !== prevSys) begin
      if (arm && runLen < minPulse) minPulse = runLen;
      runLen = 1;
    end else runLen++;
    prevSys = sysClkOut;
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      if (++n > 100) begin err_count++; print_verdict(); end
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", r, x);
    chk("pslverr", e, ex);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic waitLvl(input logic v, output int c);
    c = 0;
    while (sysClkOut !== v) begin
      @(negedge clk_sys);
      if (++c > 20000) begin err_count++; print_verdict(); end
    end
  endtask
  task automatic measure(input int eh, input int ep);
    int k, hi, lo;
    waitLvl(1'b0, k);
    waitLvl(1'b1, k);
    waitLvl(1'b0, k);
    waitLvl(1'b1, k);
    waitLvl(1'b0, hi);
    waitLvl(1'b1, lo);
    chk("highTime", hi, eh);
    chk("period", hi + lo, ep);
  endtask
  task automatic cfg(input int s, input int b, input int d);
    logic [31:0] r;
    logic e;
    int n, h;
    n = 0;
    h = 0;
    wr(OFF_PLLCTRL, b);
    wr(OFF_PRESCALE, d);
    wr(OFF_SYSCTRL, s);
    r = 32'h0000_0008;
    while (r[STAT_BUSY_BIT] !== 1'b0) begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000, r, e);
      if (++n > 3000) begin err_count++; print_verdict(); end
    end
    chk("status", r, (d << 16) | (b << 2) | s);
    chk("pllEnable", pllEnable, s == 2 && b == 0);
    if (s == 3) measure(3, 6);
    else if (s == 0) measure(6, 12);
    else if (s == 1) begin
      repeat (40) begin
        @(negedge clk_sys);
        if (sysClkOut !== 1'b0) h++;
      end
      chk("heldLow", h, 0);
    end else if (b == 0) measure(2, 4);
    else measure(d == 0 ? 4 : 8 * (d / 2 + 1), 8 * (d + 1));
  endtask
  task automatic fl(input logic sq, input int n);
    int r, k;
    logic pv;
    r = 0;
    k = 0;
    wr(OFF_MEMCTRL, n);
    waitLvl(1'b1, k);
    waitLvl(1'b0, k);
    @(posedge clk_sys);
    flashReq <= 1'b1;
    flashSeq <= sq;
    pv = sysClkOut;
    k = 0;
    while (flashReady !== 1'b1) begin
      @(posedge clk_sys);
      if (pv === 1'b0 && sysClkOut === 1'b1) r++;
      pv = sysClkOut;
      if (++k > 2000) begin err_count++; print_verdict(); end
    end
    flashReq <= 1'b0;
    @(posedge clk_sys);
    chk("flashEdges", r, sq ? 1 : n + 1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, flashReq, flashSeq, arm} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(32'h98356d47));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_SYSCTRL, 32'h0000_0000, 1'b0);
    rd(OFF_PLLCTRL, 32'h0000_0001, 1'b0);
    rd(OFF_PRESCALE, 32'h0000_0000, 1'b0);
    rd(OFF_MEMCTRL, 32'h0000_0004, 1'b0);
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rd(OFF_STATUS, 32'h0000_0004, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    measure(6, 12);
    arm = 1'b1;
    cfg(3, 1, 0);
    repeat (3) fl(1'b0, 1 + $urandom % 15);
    fl(1'b1, 4);
    fl(1'b0, 1);
    for (int i = 0; i < 4; i++) cfg(2, 1, i < 3 ? i : 5);
    repeat (3) cfg(2, 1, $urandom % 40);
    cfg(2, 1, 1023);
    cfg(2, 0, 7);
    cfg(1, 1, 0);
    cfg(0, 1, 0);
    chk("minPulseOk", minPulse >= 2, 1);
    print_verdict();
  end
endmodule // tb
